// File: logic/bvsel_top.v
// Summary of operation
// RULE1: The loader is kept in the last flash page and may be erased.
// RULE2: The signature is the flash byte just below the lock byte.
// RULE3: A signature of 0xa5 means a bootloader is present.
// RULE4: Any other signature value means no bootloader is present.
// RULE5: With a loader present, fetch starts at its vector after any reset.
// RULE6: The loader later stays or jumps to 0x0000; the start stays fixed.
// RULE7: With no loader, fetch starts at 0x0000 after every reset.
// RULE8: The core is held until the signature is read and the vector set.
`timescale 1ns/1ps
`include "bvsel_map.vh"

module bvsel_top (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] flash_rdata,
   output reg flash_rd,
   output reg [15:0] flash_addr,
   output reg core_hold,
   output reg [15:0] start_vec,
   output reg boot_present
);

   // =============================================
   // Sequencer states
   // One request, a fixed wait, then parked until the next reset
   localparam ST_REQ = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;

   // =============================================
   // State and next values
   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] lat_cnt;
   reg [1:0] next_lat_cnt;
   reg next_flash_rd;
   reg [15:0] next_flash_addr;
   reg next_core_hold;
   reg [15:0] next_start_vec;
   reg next_boot_present;
   wire sample_now;

   // =============================================
   // Decoders
   // Presence test on the fetched signature byte
   function sig_ok;
      input [7:0] b;
      begin
         sig_ok = (b == `BVSEL_SIG_PRESENT); // RULE3 RULE4
      end
   endfunction

   // Start vector for a presence verdict
   function [15:0] vec_for;
      input present;
      begin
         if (present) begin
            vec_for = `BVSEL_BOOT_VEC; // RULE1 RULE5
         end else begin
            vec_for = `BVSEL_RESET_VEC; // RULE7
         end
      end
   endfunction

   // High in the one cycle where the flash data is valid
   // Latency is fixed, so a counter is cheaper than a ready line from flash
   function read_due;
      input [1:0] st;
      input [1:0] cnt;
      begin
         read_due = (st == ST_WAIT) && (cnt == `BVSEL_RD_LAT);
      end
   endfunction

   assign sample_now = read_due(state, lat_cnt);

   // =============================================
   // Sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_REQ: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (sample_now) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            // Later jumps are the loader's own business
            next_state = ST_DONE; // RULE6
         end
         // Unused code falls back to a fresh read
         default: begin
            next_state = ST_REQ;
         end
      endcase
   end

   // Wait cycles of the flash read
   // Counting one past the sample point is harmless: the state moves on
   always @* begin
      next_lat_cnt = lat_cnt;
      case (state)
         ST_REQ: begin
            next_lat_cnt = `BVSEL_CNT_RST;
         end
         ST_WAIT: begin
            next_lat_cnt = lat_cnt + 2'h1;
         end
         default: begin
            next_lat_cnt = lat_cnt;
         end
      endcase
   end

   // =============================================
   // Flash request
   // Address parks on the signature byte, so nothing else is ever read
   always @* begin
      next_flash_rd = 1'h0;
      next_flash_addr = flash_addr;
      case (state)
         ST_REQ: begin
            next_flash_rd = 1'h1;
            next_flash_addr = `BVSEL_SIG_ADDR; // RULE2
         end
         default: begin
            next_flash_rd = 1'h0;
         end
      endcase
   end

   // =============================================
   // Start decision
   // Hold drops on the edge the vector lands, so the core never fetches
   // from a stale vector
   always @* begin
      next_core_hold = core_hold;
      next_start_vec = start_vec; // RULE6
      next_boot_present = boot_present;
      if (sample_now) begin
         // Erased page reads 0xff, which lands here as no loader
         next_boot_present = sig_ok(flash_rdata); // RULE3 RULE4
         next_start_vec = vec_for(sig_ok(flash_rdata)); // RULE5 RULE7
         next_core_hold = 1'h0; // RULE8
      end
   end

   // =============================================
   // Sequencer registers
   // Every reset source funnels into sys_rst, so the choice is redone
   // each time
   // State
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_REQ;
      end else begin
         state <= next_state;
      end
   end

   // Wait count
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lat_cnt <= `BVSEL_CNT_RST;
      end else begin
         lat_cnt <= next_lat_cnt;
      end
   end

   // =============================================
   // Flash request registers
   // Read strobe, high for one cycle only
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_rd <= `BVSEL_RD_RST;
      end else begin
         flash_rd <= next_flash_rd;
      end
   end

   // Read address
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flash_addr <= `BVSEL_ADDR_RST;
      end else begin
         flash_addr <= next_flash_addr;
      end
   end

   // =============================================
   // Result registers
   // Core hold, up through the whole of reset
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_hold <= `BVSEL_HOLD_RST; // RULE8
      end else begin
         core_hold <= next_core_hold;
      end
   end

   // Chosen start vector
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         start_vec <= `BVSEL_VEC_RST;
      end else begin
         start_vec <= next_start_vec;
      end
   end

   // Presence flag
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         boot_present <= `BVSEL_PRES_RST;
      end else begin
         boot_present <= next_boot_present;
      end
   end

endmodule // bvsel_top

// File: common/bvsel_map.vh
`ifndef BVSEL_MAP_VH
`define BVSEL_MAP_VH
// =============================================
// Flash geometry
`define BVSEL_ADDR_W 16
`define BVSEL_FLASH_TOP 16'h3fff
`define BVSEL_PAGE_SIZE 16'h0200
`define BVSEL_LOCK_ADDR 16'h3fff
`define BVSEL_SIG_ADDR 16'h3ffe
// =============================================
// Signature and vectors
`define BVSEL_SIG_PRESENT 8'ha5
`define BVSEL_RESET_VEC 16'h0000
`define BVSEL_BOOT_VEC 16'h3e00
// =============================================
// Flash read latency in cycles
`define BVSEL_RD_LAT 2'h1
// =============================================
// Reset values
`define BVSEL_CNT_RST 2'h0
`define BVSEL_RD_RST 1'h0
`define BVSEL_ADDR_RST 16'h0000
`define BVSEL_HOLD_RST 1'h1
`define BVSEL_VEC_RST 16'h0000
`define BVSEL_PRES_RST 1'h0
`endif

// File: dv/bvsel_props.sv
`timescale 1ns/1ps
`include "bvsel_map.vh"

// =============================================
// Checker on the top module's ports
module bvsel_props (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] flash_rdata,
   input wire flash_rd,
   input wire [15:0] flash_addr,
   input wire core_hold,
   input wire [15:0] start_vec,
   input wire boot_present
);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_adr;
      flash_rd |-> flash_addr == `BVSEL_SIG_ADDR;
   endproperty
   a_adr: assert property (p_adr) else $error("bad addr");

   property p_sig;
      $fell(core_hold) |->
         boot_present == ($past(flash_rdata) == `BVSEL_SIG_PRESENT);
   endproperty
   a_sig: assert property (p_sig) else $error("bad flag");

   property p_vec;
      !core_hold |->
         start_vec == (boot_present ? `BVSEL_BOOT_VEC : `BVSEL_RESET_VEC);
   endproperty
   a_vec: assert property (p_vec) else $error("bad vec");

   property p_hld;
      $fell(core_hold) |-> $past(flash_rd, 2);
   endproperty
   a_hld: assert property (p_hld) else $error("early");

   // Hold stays up exactly three cycles after reset release
   property p_rel;
      $fell(sys_rst) |-> core_hold [*3] ##1 !core_hold;
   endproperty
   a_rel: assert property (p_rel) else $error("bad release");

   property p_one;
      flash_rd |=> !flash_rd;
   endproperty
   a_one: assert property (p_one) else $error("long read");

   property p_stay;
      !core_hold |=>
         !core_hold && $stable(start_vec) && $stable(boot_present);
   endproperty
   a_stay: assert property (p_stay) else $error("moved");

   c_boot: cover property ($fell(core_hold) && boot_present);
   c_none: cover property ($fell(core_hold) && !boot_present);
   c_read: cover property (flash_rd);

endmodule // bvsel_props

bind bvsel_top bvsel_props u_props (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .flash_rdata(flash_rdata),
   .flash_rd(flash_rd),
   .flash_addr(flash_addr),
   .core_hold(core_hold),
   .start_vec(start_vec),
   .boot_present(boot_present)
);

// File: dv/bvsel_flash.sv
`timescale 1ns/1ps
`include "bvsel_map.vh"

// =============================================
// Program flash stand-in holding only the signature byte
module bvsel_flash (
   input wire sys_clk,
   input wire flash_rd,
   input wire [15:0] flash_addr,
   input wire [7:0] sig,
   output reg [7:0] flash_rdata
);

   initial begin
      flash_rdata = 8'h3c;
   end

   // Off-read cycles toggle so stale data never looks valid
   always @(posedge sys_clk) begin
      if (flash_rd && (flash_addr == `BVSEL_SIG_ADDR)) begin
         flash_rdata <= sig;
      end else begin
         flash_rdata <= ~flash_rdata;
      end
   end

endmodule // bvsel_flash

// File: dv/boot_vector_select_tb.sv
`timescale 1ns/1ps
`include "bvsel_map.vh"

module boot_vector_select_tb;

   reg sys_clk = 1'h0;
   reg sys_rst = 1'h1;
   reg [7:0] sig = 8'h00;
   wire [7:0] rd;
   wire frd;
   wire hold;
   wire pres;
   wire [15:0] adr;
   wire [15:0] vec;
   integer miscompares = 0;
   integer check_count = 0;
   integer cyc = 0;

   bvsel_top uut (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .flash_rdata(rd),
      .flash_rd(frd),
      .flash_addr(adr),
      .core_hold(hold),
      .start_vec(vec),
      .boot_present(pres)
   );

   bvsel_flash mem (
      .sys_clk(sys_clk),
      .flash_rd(frd),
      .flash_addr(adr),
      .sig(sig),
      .flash_rdata(rd)
   );

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // =============================================
   // Report
   task stop_test;
      begin
         $display("miscompares=%0d check_count=%0d", miscompares,
            check_count);
         if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask

   task chk;
      input [23:0] got;
      input [23:0] exp;
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: %h %h", $time, got, exp);
         end
      end
   endtask

   // =============================================
   // One reset with a given signature, judged edge by edge
   task run;
      input [7:0] s;
      input [15:0] v;
      begin
         @(posedge sys_clk);
         sig <= s;
         sys_rst <= 1'h1;
         repeat (2) @(posedge sys_clk);
         #1;
         chk(hold, `BVSEL_HOLD_RST);
         chk(vec, `BVSEL_VEC_RST);
         chk({frd, pres}, 2'h0);
         @(posedge sys_clk);
         sys_rst <= 1'h0;
         @(posedge sys_clk);
         #1;
         chk({frd, adr}, {1'h1, `BVSEL_SIG_ADDR});
         chk(hold, 1'h1);
         @(posedge sys_clk);
         #1;
         chk(frd, 1'h0);
         chk(hold, 1'h1);
         @(posedge sys_clk);
         #1;
         chk({hold, vec}, {1'h0, v});
         chk(pres, s == `BVSEL_SIG_PRESENT);
         repeat (4) @(posedge sys_clk);
         #1;
         chk({frd, hold, vec}, {2'h0, v});
      end
   endtask

   // =============================================
   // Scenarios
   task loader_test;
      begin
         run(8'ha5, `BVSEL_BOOT_VEC);
      end
   endtask

   task blank_test;
      begin
         run(8'h00, `BVSEL_RESET_VEC);
      end
   endtask

   task near_miss_test;
      begin
         run(8'ha4, `BVSEL_RESET_VEC);
         run(8'h5a, `BVSEL_RESET_VEC);
      end
   endtask

   task erased_test;
      begin
         run(8'hff, `BVSEL_RESET_VEC);
      end
   endtask

   task reload_test;
      begin
         run(8'ha5, `BVSEL_BOOT_VEC);
      end
   endtask

   // Six resets of eleven cycles each; the ceiling leaves ample room
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 200) begin
         miscompares = miscompares + 1;
         stop_test;
      end
   end

   initial begin
      loader_test;
      blank_test;
      near_miss_test;
      erased_test;
      reload_test;
      stop_test;
   end

endmodule // boot_vector_select_tb
